// ==== pad_ctrl_consts.svh ====
/*
 Constants for the pad configuration block: register offsets, field
 positions, reset values. Assumes inclusion by the package and top module.
*/
`ifndef PAD_CTRL_CONSTS_SVH
`define PAD_CTRL_CONSTS_SVH

`define OFS_INPUT_EN     12'h000
`define OFS_PULLUP_EN    12'h004
`define OFS_OUTPUT_EN    12'h008
`define OFS_ANALOG_EN    12'h00C
`define OFS_OUT_VALUE    12'h010
`define OFS_PAD_IN       12'h014
`define OFS_SLOW_CTRL    12'h018
`define OFS_SLOW_STATUS  12'h01C
`define OFS_SCHMITT_EN   12'h020
`define OFS_POWER_ON     12'h024

`define NUM_PADS         14
`define PAD_MASK_RST     14'h0000
`define SCHMITT_CAPABLE  14'h00F0

`define SLOW_IN_OE_BIT   0
`define SLOW_IN_VAL_BIT  1
`define SLOW_OUT_OE_BIT  2

`define ST_SUPPLY_ON_BIT   0
`define ST_SUPPLY_OK_BIT   1
`define ST_DEEP_SLEEP_BIT  2

`endif

// ==== pad_ctrl_pkg.sv ====
/*
 Types shared by the pad configuration block.
 Assumes pad_ctrl_consts.svh is available on the include path.
*/
`include "pad_ctrl_consts.svh"
package pad_ctrl_pkg;
   typedef logic [`NUM_PADS-1:0] pad_vec_type;

   typedef struct packed {
      pad_vec_type digital_input_enable;
      pad_vec_type pullup_enable;
      pad_vec_type digital_output_enable;
      pad_vec_type analog_function_enable;
      pad_vec_type schmitt_enable;
      pad_vec_type output_value;
      pad_vec_type power_on_control;
   } pad_ctrl_type;

   typedef struct packed {
      logic oe;
      logic value;
   } slow_pin_type;

   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_ON,
      PWR_LOW
   } supply_state_type;
endpackage

// ==== pad_config_and_slow_outputs.sv ====
/*
 Pad control for general-purpose groups 0..2 plus two slow always-on pins,
 as an AHB-Lite slave. Assumes a single AHB master, hready driven by this
 slave, and supply detector levels already synchronous to hclk.
*/
// The register addresses and register access over AHB-Lite were left to the implementer.
// Contract
// RULE_01: Groups 0-2 pads: tristate, pull-up, Schmitt, analog.
// RULE_02: Per-pad input, pull-up, output, analog, power-on controls.
// RULE_03: Analog function forces digital input enable off.
// RULE_04: Software must enable pull-up on digital inputs.
// RULE_05: Schmitt option only on four group-1 pads.
// RULE_06: Slow input pin drives software-written value.
// RULE_07: Slow pins hold outputs during deep sleep.
// RULE_08: Slow output pin follows supply threshold detector.
// RULE_09: Slow output tristate until supply first on.
// RULE_10: Below turn-off, slow output tristates or low.
// RULE_11: Slow input tristate until supply on, then software.
// RULE_12: Below turn-off, slow input holds or tristates.
// RULE_13: Reset defaults: tristate pads, reset pulldown, wake inputs.
`timescale 1ns/1ps
`include "pad_ctrl_consts.svh"
module pad_config_and_slow_outputs #(
   parameter int NUM_PADS = `NUM_PADS
) (
   input  wire logic                       hclk,
   input  wire logic                       hresetn,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   input  wire logic                       above_turn_on_threshold,
   input  wire logic                       above_turn_off_threshold,
   input  wire logic                       deep_sleep,
   input  wire pad_ctrl_pkg::pad_vec_type  pad_in,
   output pad_ctrl_pkg::pad_ctrl_type      pad_ctrl,
   output pad_ctrl_pkg::slow_pin_type      slow_crystal_input_pin,
   output pad_ctrl_pkg::slow_pin_type      slow_crystal_output_pin,
   output logic                            reset_pin_pulldown,
   output logic                            wake_pin_zero_input_enable,
   output logic                            wake_pin_one_input_enable
);
   import pad_ctrl_pkg::*;

   pad_vec_type      in_en_r, in_en_nxt;
   pad_vec_type      pu_en_r, pu_en_nxt;
   pad_vec_type      oe_r, oe_nxt;
   pad_vec_type      ana_r, ana_nxt;
   pad_vec_type      st_r, st_nxt;
   pad_vec_type      val_r, val_nxt;
   pad_vec_type      poc_r, poc_nxt;
   logic [2:0]       slow_ctrl_r, slow_ctrl_nxt;
   supply_state_type pwr_r, pwr_nxt;
   slow_pin_type     sxi_r, sxi_nxt;
   slow_pin_type     sxo_r, sxo_nxt;
   pad_ctrl_type     pad_r, pad_nxt;
   logic             wr_pend_r, wr_pend_nxt;
   logic [11:0]      wr_addr_r, wr_addr_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             bus_req;
   logic [11:0]      a;
   logic [7:0]       wr_strobe;
   logic             fixed_pd_r, fixed_pd_nxt;
   logic             wake_pin_zero_en_r, wake_pin_zero_en_nxt;
   logic             wake_pin_one_en_r, wake_pin_one_en_nxt;
   logic             ready_r, ready_nxt;
   logic             resp_r, resp_nxt;

   assign bus_req = hsel && hready && htrans[1];
   assign a       = haddr[11:0];

   // One strobe per writable register; unmapped offsets raise none
   always_comb begin
      wr_strobe = 8'h00;
      if (wr_pend_r) begin
         if (wr_addr_r == `OFS_INPUT_EN) begin
            wr_strobe[0] = 1'b1;
         end else if (wr_addr_r == `OFS_PULLUP_EN) begin
            wr_strobe[1] = 1'b1;
         end else if (wr_addr_r == `OFS_OUTPUT_EN) begin
            wr_strobe[2] = 1'b1;
         end else if (wr_addr_r == `OFS_ANALOG_EN) begin
            wr_strobe[3] = 1'b1;
         end else if (wr_addr_r == `OFS_OUT_VALUE) begin
            wr_strobe[4] = 1'b1;
         end else if (wr_addr_r == `OFS_SLOW_CTRL) begin
            wr_strobe[5] = 1'b1;
         end else if (wr_addr_r == `OFS_SCHMITT_EN) begin
            wr_strobe[6] = 1'b1;
         end else if (wr_addr_r == `OFS_POWER_ON) begin
            wr_strobe[7] = 1'b1;
         end
      end
   end

   // Register writes land in the data phase; reads answer with zero wait
   always_comb begin
      in_en_nxt     = in_en_r;
      pu_en_nxt     = pu_en_r;
      oe_nxt        = oe_r;
      ana_nxt       = ana_r;
      st_nxt        = st_r;
      val_nxt       = val_r;
      poc_nxt       = poc_r;
      slow_ctrl_nxt = slow_ctrl_r;
      wr_pend_nxt   = bus_req && hwrite;
      wr_addr_nxt   = bus_req ? a : wr_addr_r;
      rdata_nxt     = 32'h0000_0000;
      // Write data stands in the data phase, one cycle after the address
      if (wr_strobe[0]) begin
         in_en_nxt = hwdata[NUM_PADS-1:0]; // RULE_02
      end
      if (wr_strobe[1]) begin
         pu_en_nxt = hwdata[NUM_PADS-1:0];
      end
      if (wr_strobe[2]) begin
         oe_nxt = hwdata[NUM_PADS-1:0];
      end
      if (wr_strobe[3]) begin
         ana_nxt = hwdata[NUM_PADS-1:0];
      end
      if (wr_strobe[4]) begin
         val_nxt = hwdata[NUM_PADS-1:0];
      end
      if (wr_strobe[5]) begin
         slow_ctrl_nxt = hwdata[2:0];
      end
      if (wr_strobe[6]) begin
         // Only capable pads keep the bit
         st_nxt = hwdata[NUM_PADS-1:0] & `SCHMITT_CAPABLE; // RULE_05
      end
      if (wr_strobe[7]) begin
         poc_nxt = hwdata[NUM_PADS-1:0];
      end
      if (bus_req && !hwrite) begin
         if (a == `OFS_INPUT_EN) begin
            rdata_nxt[NUM_PADS-1:0] = in_en_r;
         end else if (a == `OFS_PULLUP_EN) begin
            rdata_nxt[NUM_PADS-1:0] = pu_en_r;
         end else if (a == `OFS_OUTPUT_EN) begin
            rdata_nxt[NUM_PADS-1:0] = oe_r;
         end else if (a == `OFS_ANALOG_EN) begin
            rdata_nxt[NUM_PADS-1:0] = ana_r;
         end else if (a == `OFS_OUT_VALUE) begin
            rdata_nxt[NUM_PADS-1:0] = val_r;
         end else if (a == `OFS_PAD_IN) begin
            // Pads with input off read zero
            rdata_nxt[NUM_PADS-1:0] = pad_in & pad_r.digital_input_enable;
         end else if (a == `OFS_SLOW_CTRL) begin
            rdata_nxt[2:0] = slow_ctrl_r;
         end else if (a == `OFS_SLOW_STATUS) begin
            rdata_nxt[`ST_SUPPLY_ON_BIT]  = (pwr_r == PWR_ON);
            rdata_nxt[`ST_SUPPLY_OK_BIT]  = (pwr_r != PWR_OFF);
            rdata_nxt[`ST_DEEP_SLEEP_BIT] = deep_sleep;
         end else if (a == `OFS_SCHMITT_EN) begin
            rdata_nxt[NUM_PADS-1:0] = st_r;
         end else if (a == `OFS_POWER_ON) begin
            rdata_nxt[NUM_PADS-1:0] = poc_r;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_en_r     <= `PAD_MASK_RST; // RULE_13
         pu_en_r     <= `PAD_MASK_RST;
         oe_r        <= `PAD_MASK_RST;
         ana_r       <= `PAD_MASK_RST;
         st_r        <= `PAD_MASK_RST;
         val_r       <= `PAD_MASK_RST;
         poc_r       <= `PAD_MASK_RST;
         slow_ctrl_r <= 3'h0;
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 12'h000;
         rdata_r     <= 32'h0000_0000;
      end else begin
         in_en_r     <= in_en_nxt;
         pu_en_r     <= pu_en_nxt;
         oe_r        <= oe_nxt;
         ana_r       <= ana_nxt;
         st_r        <= st_nxt;
         val_r       <= val_nxt;
         poc_r       <= poc_nxt;
         slow_ctrl_r <= slow_ctrl_nxt;
         wr_pend_r   <= wr_pend_nxt;
         wr_addr_r   <= wr_addr_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   // Pad drive, registered so every pad output comes from a flop
   always_comb begin
      pad_nxt.digital_input_enable   = in_en_r & ~ana_r; // RULE_03
      // Pull-up on inputs is software's duty; not forced here
      pad_nxt.pullup_enable          = pu_en_r; // RULE_01
      pad_nxt.digital_output_enable  = oe_r;
      pad_nxt.analog_function_enable = ana_r;
      pad_nxt.schmitt_enable         = st_r & `SCHMITT_CAPABLE; // RULE_05
      pad_nxt.output_value           = val_r;
      pad_nxt.power_on_control       = poc_r;
   end

   // Supply tracking; deep sleep freezes the slow pins
   always_comb begin
      pwr_nxt = pwr_r;
      sxi_nxt = sxi_r;
      sxo_nxt = sxo_r;
      case (pwr_r)
         PWR_OFF: begin
            if (above_turn_on_threshold) begin
               pwr_nxt = PWR_ON; // RULE_09
            end
         end
         PWR_ON: begin
            if (!above_turn_off_threshold) begin
               pwr_nxt = PWR_OFF;
            end else if (!above_turn_on_threshold) begin
               pwr_nxt = PWR_LOW;
            end
         end
         PWR_LOW: begin
            if (!above_turn_off_threshold) begin
               pwr_nxt = PWR_OFF;
            end else if (above_turn_on_threshold) begin
               pwr_nxt = PWR_ON;
            end
         end
         default: pwr_nxt = PWR_OFF;
      endcase
      if (!deep_sleep) begin // RULE_07
         if (pwr_nxt == PWR_OFF) begin
            // Tristate chosen below turn-off; low is equally allowed
            sxo_nxt.oe = 1'b0; // RULE_10
            sxi_nxt.oe = 1'b0; // RULE_12
         end else begin
            sxo_nxt.oe    = slow_ctrl_r[`SLOW_OUT_OE_BIT];
            sxo_nxt.value = (pwr_nxt == PWR_ON); // RULE_08
            sxi_nxt.oe    = slow_ctrl_r[`SLOW_IN_OE_BIT]; // RULE_11
            sxi_nxt.value = slow_ctrl_r[`SLOW_IN_VAL_BIT]; // RULE_06
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_r <= PWR_OFF;
         sxi_r <= '0; // RULE_11
         sxo_r <= '0; // RULE_09
         pad_r <= '0; // RULE_13
      end else begin
         pwr_r <= pwr_nxt;
         sxi_r <= sxi_nxt;
         sxo_r <= sxo_nxt;
         pad_r <= pad_nxt;
      end
   end

   // Fixed defaults have no software control
   // Held in flops anyway so every output is registered
   always_comb begin
      fixed_pd_nxt = 1'b1; // RULE_13
      wake_pin_zero_en_nxt = 1'b1;
      wake_pin_one_en_nxt = 1'b1;
      // No wait states and never an error response
      ready_nxt    = 1'b1;
      resp_nxt     = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fixed_pd_r <= 1'b1; // RULE_13
         wake_pin_zero_en_r <= 1'b1;
         wake_pin_one_en_r <= 1'b1;
         ready_r    <= 1'b1;
         resp_r     <= 1'b0;
      end else begin
         fixed_pd_r <= fixed_pd_nxt;
         wake_pin_zero_en_r <= wake_pin_zero_en_nxt;
         wake_pin_one_en_r <= wake_pin_one_en_nxt;
         ready_r    <= ready_nxt;
         resp_r     <= resp_nxt;
      end
   end

   assign hrdata                     = rdata_r;
   assign hreadyout                  = ready_r;
   assign hresp                      = resp_r;
   assign pad_ctrl                   = pad_r;
   assign slow_crystal_input_pin     = sxi_r;
   assign slow_crystal_output_pin    = sxo_r;
   assign reset_pin_pulldown         = fixed_pd_r;
   assign wake_pin_zero_input_enable = wake_pin_zero_en_r;
   assign wake_pin_one_input_enable  = wake_pin_one_en_r;
endmodule

// ==== pad_ctrl_sva.sv ====
/*
 Port checker for the pad block.
 Assumes bind into pad_config_and_slow_outputs, one hclk domain.
*/
`timescale 1ns/1ps
module pad_ctrl_sva
   import pad_ctrl_pkg::*;
#(
   parameter int NUM_PADS = 14
) (
   input wire logic          hclk,
   input wire logic          hresetn,
   input wire logic          hsel,
   input wire logic [1:0]    htrans,
   input wire logic          hready,
   input wire logic [31:0]   hrdata,
   input wire logic          hreadyout,
   input wire logic          hresp,
   input wire logic          above_turn_on_threshold,
   input wire logic          above_turn_off_threshold,
   input wire logic          deep_sleep,
   input wire pad_ctrl_type  pad_ctrl,
   input wire slow_pin_type  slow_crystal_input_pin,
   input wire slow_pin_type  slow_crystal_output_pin,
   input wire logic          reset_pin_pulldown,
   input wire logic          wake_pin_zero_input_enable,
   input wire logic          wake_pin_one_input_enable
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic seen_on_r;
   logic seen_on_nxt;
   // Supply seen on even in deep sleep; outputs may follow once sleep ends
   always_comb seen_on_nxt = seen_on_r | above_turn_on_threshold;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) seen_on_r <= 1'b0;
      else seen_on_r <= seen_on_nxt;
   end
   sequence drop_from_on;
      above_turn_on_threshold && above_turn_off_threshold && !deep_sleep
      ##1 !above_turn_on_threshold && above_turn_off_threshold && !deep_sleep;
   endsequence
   chk_analog_no_input: assert property (
      !(|(pad_ctrl.analog_function_enable & pad_ctrl.digital_input_enable)))
      else $error("input enable on analog pad");
   chk_schmitt_four_only: assert property (
      (pad_ctrl.schmitt_enable & ~14'h00F0) == 14'h0000)
      else $error("schmitt on wrong pad");
   chk_sleep_freeze: assert property (
      deep_sleep |=> $stable(slow_crystal_input_pin) && $stable(slow_crystal_output_pin))
      else $error("slow pin moved in deep sleep");
   chk_until_on_tristate: assert property (
      !seen_on_r |-> !slow_crystal_output_pin.oe && !slow_crystal_input_pin.oe)
      else $error("slow pin driven before supply on");
   chk_on_drives_high: assert property (
      above_turn_on_threshold && above_turn_off_threshold && !deep_sleep
      |=> slow_crystal_output_pin.value)
      else $error("slow output not high");
   chk_drop_goes_low: assert property (
      drop_from_on |=> !slow_crystal_output_pin.value)
      else $error("slow output not low");
   chk_off_tristate: assert property (
      !above_turn_off_threshold && !deep_sleep
      |=> !slow_crystal_output_pin.oe && !slow_crystal_input_pin.oe)
      else $error("slow pin driven below turn-off");
   chk_fixed_pins: assert property (
      reset_pin_pulldown && wake_pin_zero_input_enable && wake_pin_one_input_enable)
      else $error("reset or wake pin default lost");
   chk_read_idle_zero: assert property (
      !(hsel && hready && htrans[1]) |=> hrdata == 32'h0000_0000 && hreadyout && !hresp)
      else $error("read data outside data phase");
endmodule
bind pad_config_and_slow_outputs pad_ctrl_sva #(.NUM_PADS(NUM_PADS)) u_sva (.*);

// ==== pad_ext_model.sv ====
/*
 External circuitry on the pads, giving the levels the block reads.
 Assumes pad_ctrl from the block; an undriven pad without pull-up wanders.
*/
`timescale 1ns/1ps
module pad_ext_model
   import pad_ctrl_pkg::*;
(
   input  wire logic          hclk,
   input  wire pad_ctrl_type  pad_ctrl,
   output pad_vec_type        pad_in
);
   pad_vec_type float_r = 14'h2AAA;
   // Floating pads toggle so a stale level never reads as valid
   always_ff @(posedge hclk) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < $bits(pad_vec_type); i++) begin
         if (pad_ctrl.digital_output_enable[i]) pad_in[i] = pad_ctrl.output_value[i];
         else if (pad_ctrl.pullup_enable[i]) pad_in[i] = 1'b1;
         else pad_in[i] = float_r[i];
      end
   end
endmodule

// ==== tb_top.sv ====
/*
 Self-checking bench for the pad block over AHB-Lite.
 Assumes pad_ctrl_pkg, the external pad model and the checker bind.
*/
`timescale 1ns/1ps
`include "pad_ctrl_consts.svh"
module tb_top;
   import pad_ctrl_pkg::*;
   logic          hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0]   haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0]    htrans = 0;
   logic [2:0]    hsize = 3'h2;
   logic          hreadyout, hresp, rst_pd, wake_pin_zero_en, wake_pin_one_en;
   logic          above_on = 0, above_off = 0, deep_sleep = 0;
   pad_vec_type   pad_in;
   pad_ctrl_type  pad_ctrl;
   slow_pin_type  slow_in, slow_out;
   wire           hready = hreadyout;
   int            error_cnt = 0, n_tests = 0;
   always #4 hclk = ~hclk;
   pad_config_and_slow_outputs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .above_turn_on_threshold(above_on), .above_turn_off_threshold(above_off),
      .deep_sleep(deep_sleep), .pad_in(pad_in), .pad_ctrl(pad_ctrl),
      .slow_crystal_input_pin(slow_in), .slow_crystal_output_pin(slow_out),
      .reset_pin_pulldown(rst_pd), .wake_pin_zero_input_enable(wake_pin_zero_en),
      .wake_pin_one_input_enable(wake_pin_one_en));
   pad_ext_model u_ext (.hclk(hclk), .pad_ctrl(pad_ctrl), .pad_in(pad_in));
   task automatic conclude;
      $display("errors %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         error_cnt++;
         conclude();
      end
   endtask
   // Address phase held until hready, then data phase held until hready
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {20'h00000, a};
      wait_ready();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic t_reset;
      check("pad_ctrl_rst", 0, pad_ctrl);
      check("slow_rst", 0, {slow_in, slow_out});
      check("fixed_pins", 3'h7, {rst_pd, wake_pin_zero_en, wake_pin_one_en});
   endtask
   task automatic t_config;
      bus(1, `OFS_INPUT_EN, 32'h3FFF);
      bus(1, `OFS_PULLUP_EN, 32'h3FFF);
      bus(1, `OFS_ANALOG_EN, 32'h00FF);
      bus(1, `OFS_OUTPUT_EN, 32'h0FFF);
      bus(1, `OFS_OUT_VALUE, 32'h3A5A);
      bus(1, `OFS_POWER_ON, 32'h1234);
      repeat (2) @(posedge hclk);
      check("pad_ctrl", {14'h3F00, 14'h3FFF, 14'h0FFF, 14'h00FF, 14'h0000, 14'h3A5A,
         14'h1234}, pad_ctrl);
      bus(0, `OFS_PAD_IN, 32'h0);
      check("pad_in_reg", 32'h3A00, rd);
   endtask
   task automatic t_schmitt;
      bus(1, `OFS_SCHMITT_EN, 32'h3FFF);
      bus(0, `OFS_SCHMITT_EN, 32'h0);
      check("schmitt_reg", 32'h00F0, rd);
      check("schmitt_pads", 14'h00F0, pad_ctrl.schmitt_enable);
      bus(1, 12'h040, 32'hFFFF);
      bus(0, 12'h040, 32'h0);
      check("unmapped", 32'h0, rd);
   endtask
   task automatic t_slow;
      bus(1, `OFS_SLOW_CTRL, 32'h7);
      repeat (2) @(posedge hclk);
      check("slow_idle", 2'h0, {slow_in.oe, slow_out.oe});
      above_on <= 1'b1;
      above_off <= 1'b1;
      repeat (3) @(posedge hclk);
      check("slow_on", 4'hF, {slow_in, slow_out});
      bus(1, `OFS_SLOW_CTRL, 32'h5);
      repeat (2) @(posedge hclk);
      check("slow_in_sw", 2'h2, slow_in);
      deep_sleep <= 1'b1;
      above_on <= 1'b0;
      repeat (3) @(posedge hclk);
      check("slow_sleep", 4'hB, {slow_in, slow_out});
      deep_sleep <= 1'b0;
      repeat (3) @(posedge hclk);
      check("slow_low", 4'hA, {slow_in, slow_out});
      above_off <= 1'b0;
      repeat (3) @(posedge hclk);
      check("slow_off", 2'h0, {slow_in.oe, slow_out.oe});
      above_on <= 1'b1;
      above_off <= 1'b1;
      repeat (3) @(posedge hclk);
      check("slow_out_on", 2'h3, slow_out);
      above_on <= 1'b0;
      repeat (3) @(posedge hclk);
      check("slow_out_drop", 2'h2, slow_out);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_config();
      t_schmitt();
      t_slow();
      conclude();
   end
endmodule
